/* File: hdl/snse_status.v */
`timescale 1ns/100ps
`default_nettype none
`include "snse_status_map.vh"

//Contract
//- get-feature 0Fh at address C0h returns the 8-bit status word
//- set-feature 1Fh aimed at the status word changes no bit
//- write latch set by 06h, cleared by 04h or good program/erase
//- bit 7 high from random cache read start until page reaches register
//- reset accepted while cache read busy; aborts it, loads block 0 page 0
//- outcome bits cleared on reset and read start, updated on valid read
//- with correction disabled the outcome bits carry no meaning
//- after power-up, outcome reflects reading block 0 page 0
//- bit 3 set on program failure, bad address or protected region
//- bit 3 cleared by program-execute sequence and by reset
//- bit 2 set on erase failure or lock; cleared at erase start, reset
//- bit 0 high while program, read, erase, cache busy, reset or init run
//- correction enable is config bit 4 at B0h, default enabled
//- reset command leaves the configuration register unchanged
//- program with correction computes check code, stores it in spare area
//- read recomputes code, compares, corrects up to eight bits, then outputs
//- outcome encoding 000,001,010,011,101; other codes reserved
//- unique id and parameter page reads bypass correction
module snse_status #(
    parameter CODE_W = 16
) (
    input  wire              clk_sys,
    input  wire              rst,
    input  wire              cmd_valid,
    input  wire [7:0]        cmd_opcode,
    input  wire [7:0]        feat_addr,
    input  wire [7:0]        feat_wdata,
    output reg  [7:0]        feat_rdata_reg,
    output reg               feat_rvalid_reg,
    output reg               array_go_reg,
    output reg  [7:0]        array_op_reg,
    output reg               cache_abort_reg,
    output wire              ecc_enable,
    input  wire              init_done,
    input  wire              cache_ready,
    input  wire              cache_xfer_done,
    input  wire              prog_done,
    input  wire              prog_ok,
    input  wire              erase_done,
    input  wire              erase_ok,
    input  wire              target_bad,
    input  wire              read_done,
    input  wire              read_bypass,
    input  wire [3:0]        err_bits,
    input  wire              ecc_byte_valid,
    input  wire [7:0]        ecc_byte,
    input  wire [CODE_W-1:0] stored_code,
    output reg  [CODE_W-1:0] spare_code_reg,
    output reg               spare_code_we_reg,
    output reg               data_release_reg
);
    localparam [1:0] RUN_IDLE  = 2'h0;
    localparam [1:0] RUN_PROG  = 2'h1;
    localparam [1:0] RUN_READ  = 2'h2;
    localparam [1:0] RUN_ERASE = 2'h3;

    reg       cache_pend_reg;
    reg [2:0] outcome_reg;
    reg       prog_fail_reg;
    reg       erase_fail_reg;
    reg       write_latch_reg;
    reg       op_running_reg;
    reg [7:0] config_reg;
    reg [1:0] run_reg;
    reg       cache_busy_reg;
    reg       code_stored_reg;

    reg       cache_pend_next;
    reg [2:0] outcome_next;
    reg       prog_fail_next;
    reg       erase_fail_next;
    reg       write_latch_next;
    reg       op_running_next;
    reg [7:0] config_next;
    reg [1:0] run_next;
    reg       cache_busy_next;

    wire [CODE_W-1:0] code_now;
    wire              code_bad;
    wire [7:0]        status_word;

    wire is_get    = cmd_valid && cmd_opcode == `SNSE_OP_GET_FEATURE;
    wire is_set    = cmd_valid && cmd_opcode == `SNSE_OP_SET_FEATURE;
    wire is_wen    = cmd_valid && cmd_opcode == `SNSE_OP_WRITE_ENABLE;
    wire is_wdis   = cmd_valid && cmd_opcode == `SNSE_OP_WRITE_DISABLE;
    wire is_reset  = cmd_valid && cmd_opcode == `SNSE_OP_RESET;
    wire is_prog   = cmd_valid && cmd_opcode == `SNSE_OP_PROG_EXEC;
    wire is_erase  = cmd_valid && cmd_opcode == `SNSE_OP_BLOCK_ERASE;
    wire is_rand   = cmd_valid && cmd_opcode == `SNSE_OP_CACHE_RANDOM;
    wire is_read   = cmd_valid && (cmd_opcode == `SNSE_OP_PAGE_READ ||
                     cmd_opcode == `SNSE_OP_CACHE_LAST);
    wire busy_any  = op_running_reg;
    wire prog_go   = is_prog && !busy_any && write_latch_reg;
    wire erase_go  = is_erase && !busy_any && write_latch_reg;
    wire read_go   = (is_read || is_rand) && !busy_any;
    wire ecc_live  = config_reg[`SNSE_CFG_ECC_EN];

    // maps corrected bit count to outcome code; never a reserved code
    function [2:0] grade;
        input       mismatch;
        input [3:0] bits;
        begin
            if (!mismatch && bits == 4'h0)
                grade = `SNSE_OC_NONE;
            else if (bits == 4'h0 || bits > 4'h8)
                grade = `SNSE_OC_UNCORR;
            else if (bits <= 4'h3)
                grade = `SNSE_OC_FIX_1_3;
            else if (bits <= 4'h6)
                grade = `SNSE_OC_FIX_4_6;
            else
                grade = `SNSE_OC_FIX_7_8;
        end
    endfunction

    snse_check_code #(
        .CODE_W(CODE_W)
    ) u_code (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .code_clear   (prog_go || read_go || is_reset),
        .byte_valid   (ecc_byte_valid && ecc_live && !read_bypass),
        .byte_in      (ecc_byte),
        .stored_code  (stored_code),
        .code_reg     (code_now),
        .code_mismatch(code_bad)
    );

    assign ecc_enable = ecc_live;

    assign status_word = {cache_pend_reg, outcome_reg, prog_fail_reg,
                          erase_fail_reg, write_latch_reg, op_running_reg};

    always @* begin
        cache_pend_next  = cache_pend_reg;
        outcome_next     = outcome_reg;
        prog_fail_next   = prog_fail_reg;
        erase_fail_next  = erase_fail_reg;
        write_latch_next = write_latch_reg;
        op_running_next  = op_running_reg;
        config_next      = config_reg;
        run_next         = run_reg;
        cache_busy_next  = cache_busy_reg;

        // configuration write; status word writes fall through untouched
        if (is_set && feat_addr == `SNSE_FA_CONFIG)
            config_next = feat_wdata;

        if (is_wdis)
            write_latch_next = 1'b0;

        if (is_reset) begin
            prog_fail_next  = 1'b0;
            erase_fail_next = 1'b0;
            outcome_next    = `SNSE_OC_NONE;
            cache_pend_next = 1'b0;
            cache_busy_next = 1'b0;
            op_running_next = 1'b1;
            run_next        = RUN_READ;
            // config_reg kept as is
        end else begin
            if (prog_go) begin
                prog_fail_next  = 1'b0;
                op_running_next = 1'b1;
                run_next        = RUN_PROG;
            end
            if (erase_go) begin
                erase_fail_next = 1'b0;
                op_running_next = 1'b1;
                run_next        = RUN_ERASE;
            end
            if (read_go) begin
                outcome_next    = `SNSE_OC_NONE;
                op_running_next = 1'b1;
                run_next        = RUN_READ;
            end
            if (is_rand && !busy_any) begin
                cache_pend_next = 1'b1;
                cache_busy_next = 1'b1;
            end

            case (run_reg)
                RUN_PROG: begin
                    if (prog_done) begin
                        op_running_next = 1'b0;
                        run_next        = RUN_IDLE;
                        if (!prog_ok || target_bad)
                            prog_fail_next = 1'b1;
                        else
                            write_latch_next = 1'b0;
                    end
                end
                RUN_ERASE: begin
                    if (erase_done) begin
                        op_running_next = 1'b0;
                        run_next        = RUN_IDLE;
                        if (!erase_ok || target_bad)
                            erase_fail_next = 1'b1;
                        else
                            write_latch_next = 1'b0;
                    end
                end
                RUN_READ: begin
                    if (read_done) begin
                        run_next = RUN_IDLE;
                        if (!cache_busy_reg)
                            op_running_next = 1'b0;
                        if (ecc_live && !read_bypass)
                            outcome_next = grade(code_bad, err_bits);
                        else
                            outcome_next = `SNSE_OC_NONE;
                    end
                end
                RUN_IDLE: begin
                end
                default: begin
                    run_next = RUN_IDLE;
                end
            endcase

            // random cache read: busy ends once the cache is ready
            if (cache_busy_reg && cache_ready) begin
                cache_busy_next = 1'b0;
                if (run_reg == RUN_IDLE)
                    op_running_next = 1'b0;
            end
            // a new random read in the same cycle keeps the bit set
            if (cache_pend_reg && cache_xfer_done && !(is_rand && !busy_any))
                cache_pend_next = 1'b0;
            // init finished without a graded page
            if (init_done && run_reg == RUN_READ && !read_done) begin
                run_next = RUN_IDLE;
                if (!cache_busy_reg)
                    op_running_next = 1'b0;
            end
        end

        // set wins over a clear in the same cycle
        if (is_wen)
            write_latch_next = 1'b1;
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cache_pend_reg  <= 1'b0;
            outcome_reg     <= `SNSE_OC_NONE;
            prog_fail_reg   <= 1'b0;
            erase_fail_reg  <= 1'b0;
            write_latch_reg <= 1'b0;
            op_running_reg  <= 1'b1;
            config_reg      <= `SNSE_CFG_RESET;
            run_reg         <= RUN_READ;
            cache_busy_reg  <= 1'b0;
        end else begin
            cache_pend_reg  <= cache_pend_next;
            outcome_reg     <= outcome_next;
            prog_fail_reg   <= prog_fail_next;
            erase_fail_reg  <= erase_fail_next;
            write_latch_reg <= write_latch_next;
            op_running_reg  <= op_running_next;
            config_reg      <= config_next;
            run_reg         <= run_next;
            cache_busy_reg  <= cache_busy_next;
        end
    end

    // feature reads, array launch, code store and data release
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            feat_rdata_reg    <= 8'h00;
            feat_rvalid_reg   <= 1'b0;
            array_go_reg      <= 1'b0;
            array_op_reg      <= 8'h00;
            cache_abort_reg   <= 1'b0;
            spare_code_reg    <= {CODE_W{1'b0}};
            spare_code_we_reg <= 1'b0;
            data_release_reg  <= 1'b0;
            code_stored_reg   <= 1'b0;
        end else begin
            feat_rvalid_reg <= is_get;
            if (is_get && feat_addr == `SNSE_FA_STATUS)
                feat_rdata_reg <= status_word;
            else if (is_get && feat_addr == `SNSE_FA_CONFIG)
                feat_rdata_reg <= config_reg;
            else if (is_get)
                feat_rdata_reg <= 8'h00;
            array_go_reg <= is_reset || prog_go || erase_go || read_go;
            if (is_reset || prog_go || erase_go || read_go)
                array_op_reg <= cmd_opcode;
            cache_abort_reg <= is_reset && cache_pend_reg;
            spare_code_we_reg <= 1'b0;
            // one code store per program
            if (prog_go)
                code_stored_reg <= 1'b0;
            if (run_reg == RUN_PROG && ecc_live &&
                    ecc_byte_valid == 1'b0 && !code_stored_reg &&
                    !prog_done) begin
                spare_code_reg    <= code_now;
                spare_code_we_reg <= 1'b1;
                code_stored_reg   <= 1'b1;
            end
            if (read_go || is_reset)
                data_release_reg <= 1'b0;
            else if (run_reg == RUN_READ && read_done)
                data_release_reg <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/snse_status_map.vh */
`ifndef SNSE_STATUS_MAP_VH
`define SNSE_STATUS_MAP_VH

// host opcodes
`define SNSE_OP_GET_FEATURE   8'h0f
`define SNSE_OP_SET_FEATURE   8'h1f
`define SNSE_OP_WRITE_ENABLE  8'h06
`define SNSE_OP_WRITE_DISABLE 8'h04
`define SNSE_OP_PROG_EXEC     8'h10
`define SNSE_OP_PAGE_READ     8'h13
`define SNSE_OP_CACHE_RANDOM  8'h30
`define SNSE_OP_CACHE_LAST    8'h3f
`define SNSE_OP_BLOCK_ERASE   8'hd8
`define SNSE_OP_RESET         8'hff

// feature addresses
`define SNSE_FA_STATUS        8'hc0
`define SNSE_FA_CONFIG        8'hb0

// status word bit positions
`define SNSE_ST_CACHE_PEND    7
`define SNSE_ST_OUTCOME_HI    6
`define SNSE_ST_OUTCOME_LO    4
`define SNSE_ST_PROG_FAIL     3
`define SNSE_ST_ERASE_FAIL    2
`define SNSE_ST_WRITE_LATCH   1
`define SNSE_ST_OP_RUNNING    0

// configuration register
`define SNSE_CFG_ECC_EN       4
`define SNSE_CFG_RESET        8'h10

// correction outcome codes
`define SNSE_OC_NONE          3'h0
`define SNSE_OC_FIX_1_3       3'h1
`define SNSE_OC_UNCORR        3'h2
`define SNSE_OC_FIX_4_6       3'h3
`define SNSE_OC_FIX_7_8       3'h5

// check code
`define SNSE_CODE_SEED        16'hffff
`define SNSE_CODE_POLY        16'h1021

`endif

/* File: hdl/snse_check_code.v */
`timescale 1ns/100ps
`default_nettype none
`include "snse_status_map.vh"

// running check code over the protected cache bytes
module snse_check_code #(
    parameter CODE_W = 16
) (
    input  wire              clk_sys,
    input  wire              rst,
    input  wire              code_clear,
    input  wire              byte_valid,
    input  wire [7:0]        byte_in,
    input  wire [CODE_W-1:0] stored_code,
    output reg  [CODE_W-1:0] code_reg,
    output wire              code_mismatch
);
    localparam [CODE_W-1:0] SEED = `SNSE_CODE_SEED;
    localparam [CODE_W-1:0] POLY = `SNSE_CODE_POLY;

    reg [CODE_W-1:0] code_next;

    function [CODE_W-1:0] code_step;
        input [CODE_W-1:0] c;
        input [7:0]        b;
        integer            i;
        reg   [CODE_W-1:0] t;
        begin
            t = c;
            for (i = 7; i >= 0; i = i - 1) begin
                if (t[CODE_W-1] ^ b[i])
                    t = {t[CODE_W-2:0], 1'b0} ^ POLY;
                else
                    t = {t[CODE_W-2:0], 1'b0};
            end
            code_step = t;
        end
    endfunction

    always @* begin
        code_next = code_reg;
        if (code_clear)
            code_next = SEED;
        else if (byte_valid)
            code_next = code_step(code_reg, byte_in);
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            code_reg <= SEED;
        else
            code_reg <= code_next;
    end

    assign code_mismatch = (code_reg != stored_code);
endmodule
`default_nettype wire

/* File: verification/snse_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
`include "snse_status_map.vh"
// host side: issues decoded commands, reads features
module snse_host_model (
    input  wire        clk_sys,
    output logic       cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [7:0] feat_addr,
    output logic [7:0] feat_wdata,
    input  wire  [7:0] feat_rdata_reg,
    input  wire        feat_rvalid_reg
);
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        feat_addr = 8'h00;
        feat_wdata = 8'h00;
    end
    // one command, taken at one edge, then a quiet cycle
    task send(input [7:0] op, input [7:0] fa, input [7:0] wd);
        begin
            @(negedge clk_sys);
            cmd_valid = 1'b1;
            cmd_opcode = op;
            feat_addr = fa;
            feat_wdata = wd;
            @(negedge clk_sys);
            cmd_valid = 1'b0;
            @(negedge clk_sys);
        end
    endtask
    // answer is registered at the taking edge, read at the next negedge
    task get(input [7:0] fa, output [8:0] d);
        begin
            @(negedge clk_sys);
            cmd_valid = 1'b1;
            cmd_opcode = `SNSE_OP_GET_FEATURE;
            feat_addr = fa;
            @(negedge clk_sys);
            cmd_valid = 1'b0;
            d = {feat_rvalid_reg, feat_rdata_reg};
        end
    endtask
    // write enable always precedes program or erase
    task wr_op(input [7:0] op);
        begin
            send(`SNSE_OP_WRITE_ENABLE, 8'h00, 8'h00);
            send(op, 8'h00, 8'h00);
        end
    endtask
endmodule
`default_nettype wire

/* File: verification/snse_status_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "snse_status_map.vh"
module snse_status_properties #(
    parameter CODE_W = 16
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire logic [7:0] feat_addr,
    input wire logic [7:0] feat_rdata_reg,
    input wire logic       feat_rvalid_reg,
    input wire logic       array_go_reg,
    input wire logic [7:0] array_op_reg,
    input wire logic       cache_abort_reg,
    input wire logic       ecc_enable,
    input wire logic       ecc_byte_valid,
    input wire logic       spare_code_we_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire get_c = cmd_valid && cmd_opcode == `SNSE_OP_GET_FEATURE;
    wire rst_c = cmd_valid && cmd_opcode == `SNSE_OP_RESET;
    wire cfg_w = cmd_valid && cmd_opcode == `SNSE_OP_SET_FEATURE
                 && feat_addr == `SNSE_FA_CONFIG;
    a_get_answer: assert property (get_c |=> feat_rvalid_reg)
        else $error("feature read not answered");
    a_answer_cause: assert property (feat_rvalid_reg |-> $past(get_c))
        else $error("answer without feature read");
    a_outcome_legal: assert property (feat_rvalid_reg
        && $past(feat_addr) == `SNSE_FA_STATUS
        |-> !(feat_rdata_reg[6:4] inside {3'h4, 3'h6, 3'h7}))
        else $error("reserved outcome code reported");
    a_cfg_read: assert property (feat_rvalid_reg
        && $past(feat_addr) == `SNSE_FA_CONFIG
        |-> feat_rdata_reg[`SNSE_CFG_ECC_EN] == $past(ecc_enable))
        else $error("config read disagrees with enable");
    a_cfg_hold: assert property (!cfg_w |=> $stable(ecc_enable))
        else $error("enable changed without config write");
    a_cfg_reset: assert property (rst_c |=> $stable(ecc_enable))
        else $error("reset command changed enable");
    a_abort_cause: assert property (cache_abort_reg |-> $past(rst_c))
        else $error("abort without reset command");
    a_prog_launch: assert property (array_go_reg
        && array_op_reg == `SNSE_OP_PROG_EXEC
        |-> $past(cmd_valid && cmd_opcode == `SNSE_OP_PROG_EXEC))
        else $error("program launch without command");
    a_spare_write: assert property (spare_code_we_reg
        |-> $past(!ecc_byte_valid))
        else $error("code stored while bytes still arrive");
    cover property (get_c ##1 feat_rvalid_reg);
    cover property (cache_abort_reg);
    cover property (spare_code_we_reg);
endmodule
bind snse_status snse_status_properties #(.CODE_W(CODE_W)) u_props (
    .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .feat_addr(feat_addr),
    .feat_rdata_reg(feat_rdata_reg), .feat_rvalid_reg(feat_rvalid_reg),
    .array_go_reg(array_go_reg), .array_op_reg(array_op_reg),
    .cache_abort_reg(cache_abort_reg), .ecc_enable(ecc_enable),
    .ecc_byte_valid(ecc_byte_valid), .spare_code_we_reg(spare_code_we_reg));
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "snse_status_map.vh"
module testbench;
    logic        clk_sys, rst, cmd_valid, feat_rvalid_reg, array_go_reg;
    logic        cache_abort_reg, ecc_enable, init_done, cache_ready;
    logic        cache_xfer_done, prog_done, prog_ok, erase_done, erase_ok;
    logic        target_bad, read_done, read_bypass, ecc_byte_valid;
    logic        spare_code_we_reg, data_release_reg;
    logic [7:0]  cmd_opcode, feat_addr, feat_wdata, feat_rdata_reg;
    logic [7:0]  array_op_reg, ecc_byte;
    logic [3:0]  err_bits;
    logic [15:0] stored_code, spare_code_reg, code_seen, exp_code;
    logic [8:0]  rd;
    integer      err_count, checks_done, cyc, go_n, abort_n, we_n, i;
    snse_status dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .feat_addr(feat_addr),
        .feat_wdata(feat_wdata), .feat_rdata_reg(feat_rdata_reg),
        .feat_rvalid_reg(feat_rvalid_reg), .array_go_reg(array_go_reg),
        .array_op_reg(array_op_reg), .cache_abort_reg(cache_abort_reg),
        .ecc_enable(ecc_enable), .init_done(init_done),
        .cache_ready(cache_ready), .cache_xfer_done(cache_xfer_done),
        .prog_done(prog_done), .prog_ok(prog_ok), .erase_done(erase_done),
        .erase_ok(erase_ok), .target_bad(target_bad),
        .read_done(read_done), .read_bypass(read_bypass),
        .err_bits(err_bits), .ecc_byte_valid(ecc_byte_valid),
        .ecc_byte(ecc_byte), .stored_code(stored_code),
        .spare_code_reg(spare_code_reg),
        .spare_code_we_reg(spare_code_we_reg),
        .data_release_reg(data_release_reg));
    snse_host_model host (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_opcode), .feat_addr(feat_addr),
        .feat_wdata(feat_wdata), .feat_rdata_reg(feat_rdata_reg),
        .feat_rvalid_reg(feat_rvalid_reg));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // event counters and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (array_go_reg === 1'b1) go_n <= go_n + 1;
        if (cache_abort_reg === 1'b1) abort_n <= abort_n + 1;
        if (spare_code_we_reg === 1'b1) begin
            we_n <= we_n + 1;
            code_seen <= spare_code_reg;
        end
        if (cyc == 20000) begin
            err_count = err_count + 1;
            finish_test;
        end
    end
    function [15:0] crc(input [15:0] c, input [7:0] b);
        integer k;
        begin
            crc = c ^ {b, 8'h00};
            for (k = 0; k < 8; k = k + 1)
                crc = {crc[14:0], 1'b0} ^ (crc[15] ? 16'h1021 : 16'h0000);
        end
    endfunction
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("unexpected %s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask
    task st(input [7:0] e);
        begin
            host.get(`SNSE_FA_STATUS, rd);
            chk("status", {8'h01, e}, {7'h00, rd});
        end
    endtask
    task cf(input [7:0] e);
        begin
            host.get(`SNSE_FA_CONFIG, rd);
            chk("config", {8'h01, e}, {7'h00, rd});
        end
    endtask
    // one-cycle far-side event pulse
    task ev(input integer k);
        begin
            @(negedge clk_sys);
            case (k)
                0: init_done = 1'b1;
                1: cache_ready = 1'b1;
                2: cache_xfer_done = 1'b1;
                3: prog_done = 1'b1;
                4: erase_done = 1'b1;
                default: read_done = 1'b1;
            endcase
            @(negedge clk_sys);
            {init_done, cache_ready, cache_xfer_done} = 3'h0;
            {prog_done, erase_done, read_done} = 3'h0;
            @(negedge clk_sys);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d, errors %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    initial begin
        {err_count, checks_done, cyc, go_n, abort_n, we_n} = {6{32'h0}};
        {init_done, cache_ready, cache_xfer_done, prog_done} = 4'h0;
        {prog_ok, erase_done, erase_ok, target_bad} = 4'h0;
        {read_done, read_bypass, ecc_byte_valid} = 3'h0;
        {err_bits, ecc_byte, stored_code, code_seen} = {12'h0, 16'hffff, 16'h0};
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        st(8'h01);
        ev(0);
        st(8'h00);
        cf(8'h10);
        host.send(`SNSE_OP_SET_FEATURE, `SNSE_FA_STATUS, 8'hff);
        st(8'h00);
        host.send(`SNSE_OP_WRITE_ENABLE, 8'h00, 8'h00);
        st(8'h02);
        host.send(`SNSE_OP_WRITE_DISABLE, 8'h00, 8'h00);
        st(8'h00);
        host.send(`SNSE_OP_PROG_EXEC, 8'h00, 8'h00);
        st(8'h00);
        chk("launches", 16'h0000, go_n[15:0]);
        host.send(`SNSE_OP_WRITE_ENABLE, 8'h00, 8'h00);
        exp_code = `SNSE_CODE_SEED;
        fork
            host.send(`SNSE_OP_PROG_EXEC, 8'h00, 8'h00);
            begin
                repeat (2) @(negedge clk_sys);
                for (i = 0; i < 3; i = i + 1) begin
                    ecc_byte_valid = 1'b1;
                    ecc_byte = i[7:0] ^ 8'h5a;
                    exp_code = crc(exp_code, ecc_byte);
                    @(negedge clk_sys);
                end
                ecc_byte_valid = 1'b0;
            end
        join
        st(8'h03);
        chk("code writes", 16'h0001, we_n[15:0]);
        chk("spare code", exp_code, code_seen);
        ev(3);
        st(8'h0a);
        host.send(`SNSE_OP_PROG_EXEC, 8'h00, 8'h00);
        st(8'h03);
        prog_ok = 1'b1;
        ev(3);
        st(8'h00);
        target_bad = 1'b1;
        host.wr_op(`SNSE_OP_PROG_EXEC);
        ev(3);
        st(8'h0a);
        chk("code writes", 16'h0003, we_n[15:0]);
        target_bad = 1'b0;
        host.send(`SNSE_OP_WRITE_DISABLE, 8'h00, 8'h00);
        host.wr_op(`SNSE_OP_BLOCK_ERASE);
        ev(4);
        st(8'h0e);
        host.send(`SNSE_OP_BLOCK_ERASE, 8'h00, 8'h00);
        st(8'h0b);
        erase_ok = 1'b1;
        ev(4);
        st(8'h08);
        chk("launches", 16'h0005, go_n[15:0]);
        erase_ok = 1'b0;
        host.wr_op(`SNSE_OP_BLOCK_ERASE);
        ev(4);
        host.send(`SNSE_OP_WRITE_DISABLE, 8'h00, 8'h00);
        host.send(`SNSE_OP_RESET, 8'h00, 8'h00);
        st(8'h01);
        ev(0);
        host.send(`SNSE_OP_CACHE_RANDOM, 8'h00, 8'h00);
        st(8'h81);
        ev(5);
        st(8'h81);
        ev(1);
        st(8'h80);
        ev(2);
        st(8'h00);
        host.send(`SNSE_OP_CACHE_RANDOM, 8'h00, 8'h00);
        host.send(`SNSE_OP_RESET, 8'h00, 8'h00);
        chk("aborts", 16'h0001, abort_n[15:0]);
        st(8'h01);
        stored_code = 16'h1234;
        err_bits = 4'h2;
        ev(5);
        st(8'h10);
        for (i = 0; i < 7; i = i + 1) begin
            host.send(`SNSE_OP_PAGE_READ, 8'h00, 8'h00);
            st(8'h01);
            chk("release", 16'h0000, {15'h0, data_release_reg});
            err_bits = 28'h1346789 >> (24 - 4 * i);
            ev(5);
            st({1'b0, 3'(28'h1133552 >> (24 - 4 * i)), 4'h0});
            chk("release", 16'h0001, {15'h0, data_release_reg});
        end
        read_bypass = 1'b1;
        host.send(`SNSE_OP_PAGE_READ, 8'h00, 8'h00);
        ev(5);
        st(8'h00);
        read_bypass = 1'b0;
        host.send(`SNSE_OP_SET_FEATURE, `SNSE_FA_CONFIG, 8'h00);
        cf(8'h00);
        host.send(`SNSE_OP_RESET, 8'h00, 8'h00);
        ev(0);
        cf(8'h00);
        host.send(`SNSE_OP_PAGE_READ, 8'h00, 8'h00);
        ev(5);
        st(8'h00);
        host.send(`SNSE_OP_SET_FEATURE, `SNSE_FA_CONFIG, 8'h10);
        cf(8'h10);
        finish_test;
    end
endmodule
`default_nettype wire
